//--- rtl/ccs_clk_mode_cfg.sv
`timescale 1ns/1ns
module ccs_clk_mode_cfg
  import ccs_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // pins and straps
  input  wire logic       power_down_input,
  input  wire logic [2:0] mode_strap,
  input  wire logic [1:0] address_select_strap,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // clocking outputs
  output logic            sensor_ref_clk_out,
  output logic      [2:0] ref_src_sel,
  output logic            parallel_video_compat_mode,
  output logic      [1:0] raw_fmt_sel,
  // control-bus configuration
  output logic      [6:0] target_addr,
  output logic            io_ref_3v3,
  output logic            link_active
);
  ccs_pwr_t   pwr_reg;
  ccs_pwr_t   pwr_next;
  logic       pdb_prev_reg;
  logic       pdb_rise;
  logic [2:0] mode_reg;
  logic       ovr_reg;
  logic [1:0] fmt_reg;
  logic [4:0] m_reg;
  logic [2:0] div_reg;
  logic [7:0] n_reg;
  logic [6:0] target_addr_reg;
  logic       io_ref_reg;
  logic [2:0] ref_src_reg;
  logic [2:0] ref_src_next;
  logic       clk_en_reg;
  logic       clk_en_next;
  logic       par_mode_reg;
  logic       link_active_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       wr_mode;
  logic       wr_fmt;
  logic       wr_mdiv;
  logic       wr_n;
  logic       running;

  // write decodes, accepted only while powered up
  assign running = (pwr_reg == ST_RUN);
  assign wr_mode = reg_wr && running && reg_addr == REG_MODE_SEL;
  assign wr_fmt  = reg_wr && running && reg_addr == REG_FMT_SEL;
  assign wr_mdiv = reg_wr && running && reg_addr == REG_CLK_M_DIV;
  assign wr_n    = reg_wr && running && reg_addr == REG_CLK_N;

  // rising edge of the power-down input
  assign pdb_rise = power_down_input && !pdb_prev_reg; // RQ13

  // previous power-down level
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pdb_prev_reg <= 1'b0;
    end else begin
      pdb_prev_reg <= power_down_input;
    end
  end

  // power state transitions
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      ST_DOWN: begin
        if (pdb_rise) begin
          pwr_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!power_down_input) begin
          pwr_next = ST_DOWN;
        end
      end
    endcase
  end

  // power state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pwr_reg <= ST_DOWN;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  // mode field: strap at power-up, override by software
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= MODE_SYNC;
      ovr_reg  <= 1'b0;
    end else if (pdb_rise) begin
      mode_reg <= mode_strap; // RQ5 RQ13
      ovr_reg  <= 1'b0;
    end else if (!running) begin
      ovr_reg <= 1'b0;
    end else if (wr_mode) begin
      ovr_reg <= reg_wdata[OVR_BIT];
      if (reg_wdata[OVR_BIT] || ovr_reg) begin
        mode_reg <= reg_wdata[MODE_MSB:0]; // RQ14
      end
    end
  end

  // parallel video format, low-frequency twelve-bit refused
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fmt_reg <= FMT_RAW_TEN_BIT_FORMAT;
    end else if (!running) begin
      fmt_reg <= FMT_RAW_TEN_BIT_FORMAT;
    end else if (wr_fmt) begin
      if (reg_wdata[FMT_MSB:0] == FMT_RAW_TEN_BIT_FORMAT ||
          reg_wdata[FMT_MSB:0] == FMT_RAW_TWELVE_BIT_HIGH_FREQ) begin
        fmt_reg <= reg_wdata[FMT_MSB:0]; // RQ10
      end
    end
  end

  // output clock ratio registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      m_reg   <= RST_M;
      div_reg <= RST_DIV_CODE;
      n_reg   <= RST_N;
    end else if (!running) begin
      m_reg   <= RST_M;
      div_reg <= RST_DIV_CODE;
      n_reg   <= RST_N;
    end else begin
      if (wr_mdiv) begin
        m_reg   <= reg_wdata[M_MSB:0]; // RQ3
        div_reg <= reg_wdata[DIV_MSB:DIV_LSB];
      end
      if (wr_n) begin
        n_reg <= reg_wdata; // RQ3
      end
    end
  end

  // control-bus address and I/O level, caught with the mode strap
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      target_addr_reg <= ADDR_LO;
      io_ref_reg      <= 1'b0;
    end else if (pdb_rise) begin
      target_addr_reg <= address_select_strap[0] ? ADDR_HI : ADDR_LO; // RQ11 RQ12 RQ15
      io_ref_reg      <= address_select_strap[1]; // RQ12 RQ15
    end
  end

  // reference source and clock-out enable per mode
  always_comb begin
    ref_src_next = REF_NONE;
    clk_en_next  = 1'b0;
    if (running) begin
      if (mode_reg == MODE_SYNC) begin
        ref_src_next = REF_BC; // RQ6
        clk_en_next  = 1'b1; // RQ1
      end else if (mode_reg == MODE_EXT) begin
        ref_src_next = REF_EXT; // RQ7
        clk_en_next  = 1'b1; // RQ1
      end else if (mode_reg == MODE_AON) begin
        ref_src_next = REF_AON; // RQ8
        clk_en_next  = 1'b0; // RQ2
      end else if (mode_reg == MODE_PAR) begin
        ref_src_next = REF_EXT; // RQ9
        clk_en_next  = 1'b1;
      end
    end
  end

  // registered clocking controls
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ref_src_reg     <= REF_NONE;
      clk_en_reg      <= 1'b0;
      par_mode_reg    <= 1'b0;
      link_active_reg <= 1'b0;
    end else begin
      ref_src_reg     <= ref_src_next;
      clk_en_reg      <= clk_en_next;
      par_mode_reg    <= running && mode_reg == MODE_PAR; // RQ9
      link_active_reg <= running && ref_src_next != REF_NONE;
    end
  end

  // register read mux, unmapped reads return zero
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_STATUS:    rdata_next = {3'h0, ref_src_reg, running, clk_en_reg};
        REG_MODE_SEL:  rdata_next = {3'h0, ovr_reg, 1'b0, mode_reg}; // RQ5 RQ14
        REG_FMT_SEL:   rdata_next = {6'h00, fmt_reg};
        REG_CLK_M_DIV: rdata_next = {div_reg, m_reg};
        REG_CLK_N:     rdata_next = n_reg;
        REG_TARGET:    rdata_next = {io_ref_reg, target_addr_reg};
        default:       rdata_next = 8'h00;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // fractional output clock generator
  ccs_frac_clkgen u_clkgen (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .enable   (clk_en_reg),
    .m_val    (m_reg),
    .n_val    (n_reg),
    .div_code (div_reg),
    .clk_out  (sensor_ref_clk_out)
  );

  // output ports from flip-flops
  assign reg_rdata                  = rdata_reg;
  assign ref_src_sel                = ref_src_reg;
  assign parallel_video_compat_mode = par_mode_reg;
  assign raw_fmt_sel                = fmt_reg;
  assign target_addr                = target_addr_reg;
  assign io_ref_3v3                 = io_ref_reg;
  assign link_active                = link_active_reg;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_CLK_EN_SYNC_EXT: // RQ1
    assert property (running && (mode_reg == MODE_SYNC || mode_reg == MODE_EXT)
                     |=> clk_en_reg)
    else $error("clock-out not enabled in synchronous or external mode");

  AST_CLK_TOGGLES: // RQ1
    assert property ((clk_en_reg && m_reg == 5'h01 && n_reg == 8'h01 &&
                      div_reg == 3'h0)[*2]
                     |-> sensor_ref_clk_out != $past(sensor_ref_clk_out))
    else $error("clock-out not toggling at unit ratio");

  AST_CLK_OFF_AON: // RQ2
    assert property ((mode_reg == MODE_AON)[*3] |-> !sensor_ref_clk_out)
    else $error("clock-out active in internal oscillator mode");

  AST_CLK_OFF_ZERO_M: // RQ3
    assert property ((m_reg == 5'h00)[*2] |-> !sensor_ref_clk_out)
    else $error("clock-out active with zero multiplier");

  AST_N_WRITE: // RQ3
    assert property (wr_n |=> n_reg == $past(reg_wdata))
    else $error("divisor register did not take write");

  AST_MODE_READ: // RQ5
    assert property (reg_rd && reg_addr == REG_MODE_SEL
                     |=> reg_rdata[MODE_MSB:0] == $past(mode_reg))
    else $error("mode read-back mismatch");

  AST_REF_BC: // RQ6
    assert property (running && mode_reg == MODE_SYNC |=> ref_src_sel == REF_BC)
    else $error("synchronous mode not on back channel");

  AST_REF_EXT: // RQ7
    assert property (running && mode_reg == MODE_EXT |=> ref_src_sel == REF_EXT)
    else $error("external mode not on clock input");

  AST_REF_AON: // RQ8
    assert property (running && mode_reg == MODE_AON |=> ref_src_sel == REF_AON)
    else $error("internal mode not on oscillator");

  AST_PAR_MODE: // RQ9
    assert property (running && mode_reg == MODE_PAR
                     |=> parallel_video_compat_mode && ref_src_sel == REF_EXT)
    else $error("parallel video mode not selected");

  AST_LF_REFUSED: // RQ10
    assert property (wr_fmt && reg_wdata[FMT_MSB:0] == FMT_RAW_TWELVE_BIT_LOW_FREQ
                     |=> $stable(raw_fmt_sel))
    else $error("low-frequency twelve-bit format accepted");

  AST_ADDR_LEGAL: // RQ11
    assert property (target_addr == ADDR_LO || target_addr == ADDR_HI)
    else $error("target address outside the two choices");

  AST_STRAP_ADDR: // RQ12
    assert property (pdb_rise |=> target_addr == ($past(address_select_strap[0]) ?
                     ADDR_HI : ADDR_LO) && io_ref_3v3 == $past(address_select_strap[1]))
    else $error("address strap decode wrong");

  AST_STRAP_MODE: // RQ13
    assert property (pdb_rise |=> mode_reg == $past(mode_strap) && running)
    else $error("mode strap not latched on power-up");

  AST_MODE_LOCKED: // RQ14
    assert property (wr_mode && !ovr_reg && !reg_wdata[OVR_BIT] |=> $stable(mode_reg))
    else $error("mode changed without override");

  AST_ADDR_HELD: // RQ15
    assert property (!pdb_rise |=> $stable(target_addr) && $stable(io_ref_3v3))
    else $error("address settings changed while powered");

  AST_MODE_ILLEGAL_OFF: // RQ5
    assert property (running && mode_reg != MODE_SYNC && mode_reg != MODE_EXT &&
                     mode_reg != MODE_AON && mode_reg != MODE_PAR
                     |=> ref_src_sel == REF_NONE && !link_active && !clk_en_reg)
    else $error("unlisted mode code left a reference selected");

  AST_RDATA_IDLE: // RQ5
    assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not cleared outside the read cycle");

  AST_CLK_OFF_DOWN: // RQ1
    assert property ((!running)[*3] |-> !sensor_ref_clk_out)
    else $error("clock-out active while powered down");

  COV_POWER_UP:
    cover property (pdb_rise ##1 running);

  COV_OVERRIDE:
    cover property (wr_mode && reg_wdata[OVR_BIT] ##1 ovr_reg);

  COV_CLK_SYNC:
    cover property (ref_src_sel == REF_BC ##1 sensor_ref_clk_out);

  COV_LF_WRITE:
    cover property (wr_fmt && reg_wdata[FMT_MSB:0] == FMT_RAW_TWELVE_BIT_LOW_FREQ);
endmodule // ccs_clk_mode_cfg

//--- shared/ccs_pkg.sv
// Functional notes
// [RQ1] sensor clock runs in synchronous/external modes
// [RQ2] sensor clock off in internal-oscillator mode
// [RQ3] clock equals rate times M over divider times N
// [RQ4] software picks integer N/M or small divider
// [RQ5] strap sets default mode, registers read/change it
// [RQ6] mode 0 uses back channel reference
// [RQ7] mode 2 uses external clock input reference
// [RQ8] mode 3 uses always-on oscillator reference
// [RQ9] mode 5 is parallel video, external clock
// [RQ10] parallel mode refuses twelve-bit low-frequency format
// [RQ11] control-bus target with two selectable addresses
// [RQ12] address strap picks address and I/O reference
// [RQ13] mode strap latched on power-down input rising
// [RQ14] mode field writable only with override bit set
// [RQ15] address and I/O level held until power-down
package ccs_pkg;
  // register offsets
  localparam logic [7:0] REG_STATUS    = 8'h02;
  localparam logic [7:0] REG_MODE_SEL  = 8'h03;
  localparam logic [7:0] REG_FMT_SEL   = 8'h04;
  localparam logic [7:0] REG_CLK_M_DIV = 8'h06;
  localparam logic [7:0] REG_CLK_N     = 8'h07;
  localparam logic [7:0] REG_TARGET    = 8'h08;
  // field positions
  localparam int MODE_MSB = 2;
  localparam int OVR_BIT  = 4;
  localparam int M_MSB    = 4;
  localparam int DIV_LSB  = 5;
  localparam int DIV_MSB  = 7;
  localparam int FMT_MSB  = 1;
  localparam int IO_BIT   = 7;
  // mode values
  localparam logic [2:0] MODE_SYNC = 3'h0;
  localparam logic [2:0] MODE_EXT  = 3'h2;
  localparam logic [2:0] MODE_AON  = 3'h3;
  localparam logic [2:0] MODE_PAR  = 3'h5;
  // parallel video formats
  localparam logic [1:0] FMT_RAW_TEN_BIT_FORMAT    = 2'h0;
  localparam logic [1:0] FMT_RAW_TWELVE_BIT_HIGH_FREQ = 2'h1;
  localparam logic [1:0] FMT_RAW_TWELVE_BIT_LOW_FREQ = 2'h2;
  // reference source one-hot codes
  localparam logic [2:0] REF_NONE = 3'h0;
  localparam logic [2:0] REF_BC   = 3'h1;
  localparam logic [2:0] REF_EXT  = 3'h2;
  localparam logic [2:0] REF_AON  = 3'h4;
  // reset values and divider code limit
  localparam logic [4:0] RST_M        = 5'h01;
  localparam logic [7:0] RST_N        = 8'h1B;
  localparam logic [2:0] RST_DIV_CODE = 3'h2;
  localparam logic [2:0] MAX_DIV_CODE = 3'h4;
  // control-bus target addresses
  localparam logic [6:0] ADDR_LO = 7'h18;
  localparam logic [6:0] ADDR_HI = 7'h19;
  // power state
  typedef enum logic [1:0] {
    ST_DOWN = 2'b01,
    ST_RUN  = 2'b10
  } ccs_pwr_t;
endpackage

//--- rtl/ccs_frac_clkgen.sv
`timescale 1ns/1ns
module ccs_frac_clkgen
  import ccs_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // ratio settings
  input  wire logic       enable,
  input  wire logic [4:0] m_val,
  input  wire logic [7:0] n_val,
  input  wire logic [2:0] div_code,
  // clock output
  output logic            clk_out
);
  logic [4:0]  div_val;
  logic [12:0] half_per;
  logic [12:0] sum;
  logic [12:0] acc_reg;
  logic        clk_reg;

  // divider code to value, codes above four clamp to sixteen
  always_comb begin
    if (div_code > MAX_DIV_CODE) begin
      div_val = 5'h10;
    end else begin
      div_val = 5'h01 << div_code;
    end
    half_per = 13'(div_val * n_val);
    sum      = acc_reg + 13'(m_val);
  end

  // phase accumulator, toggles every div*N/M ticks
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_reg <= 13'h0000;
      clk_reg <= 1'b0;
    end else if (!enable || m_val == 5'h00 || n_val == 8'h00) begin
      acc_reg <= 13'h0000; // parked low, no ratio
      clk_reg <= 1'b0;
    end else if (sum >= half_per) begin
      // a stale or oversized remainder restarts at zero, so a ratio change
      // or a multiplier above the period cannot burst or wrap the clock
      if (sum - half_per >= half_per) begin
        acc_reg <= 13'h0000;
      end else begin
        acc_reg <= sum - half_per; // RQ3
      end
      clk_reg <= ~clk_reg;
    end else begin
      acc_reg <= sum;
    end
  end

  assign clk_out = clk_reg;
endmodule // ccs_frac_clkgen

//--- verification/ccs_sensor_model.sv
`timescale 1ns/1ns
// image sensor stand-in: times the reference clock that it receives
module ccs_sensor_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // reference clock from the serializer
  input  wire logic        sensor_ref_clk_out,
  // measured clock
  output logic      [15:0] half_period,
  output logic      [15:0] n_toggles
);
  logic        last_lvl;
  logic [15:0] cnt;

  // count cycles between level changes of the received clock
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      last_lvl    <= 1'b0;
      cnt         <= 16'h0000;
      half_period <= 16'h0000;
      n_toggles   <= 16'h0000;
    end else if (sensor_ref_clk_out !== last_lvl) begin
      last_lvl    <= sensor_ref_clk_out;
      half_period <= cnt;
      cnt         <= 16'h0001;
      n_toggles   <= n_toggles + 16'h0001;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule // ccs_sensor_model

//--- verification/clkout_mode_strap_config_tb_top.sv
`timescale 1ns/1ns
module clkout_mode_strap_config_tb_top import ccs_pkg::*;;
  // stimulus and design outputs
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        power_down_input = 1'b0;
  logic [2:0]  mode_strap = 3'h0;
  logic [1:0]  address_select_strap = 2'h0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        sensor_ref_clk_out;
  logic [2:0]  ref_src_sel;
  logic        parallel_video_compat_mode;
  logic [1:0]  raw_fmt_sel;
  logic [6:0]  target_addr;
  logic        io_ref_3v3;
  logic        link_active;
  logic [15:0] half_period;
  logic [15:0] n_toggles;
  logic [7:0]  exp_q[$];
  logic        rd_q = 1'b0;
  int          n_fail = 0;
  int          n_compared = 0;
  integer      seed = 4035;
  logic [2:0]  modes [4] = '{MODE_SYNC, MODE_EXT, MODE_AON, MODE_PAR};
  // ratio table, integer N over M ratios except the last (M of 3, N of 1)
  logic [4:0]  tm [6] = '{5'h01, 5'h01, 5'h01, 5'h01, 5'h02, 5'h03};
  logic [2:0]  td [6] = '{3'h0, 3'h1, 3'h4, 3'h7, 3'h0, 3'h0};
  logic [7:0]  tn [6] = '{8'h05, 8'h03, 8'h01, 8'h01, 8'h04, 8'h01};
  logic [15:0] te [6] = '{16'h0005, 16'h0006, 16'h0010, 16'h0010, 16'h0002, 16'h0001};

  always #50 sys_clk = ~sys_clk;

  ccs_clk_mode_cfg u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .power_down_input(power_down_input),
    .mode_strap(mode_strap), .address_select_strap(address_select_strap),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sensor_ref_clk_out(sensor_ref_clk_out),
    .ref_src_sel(ref_src_sel), .parallel_video_compat_mode(parallel_video_compat_mode),
    .raw_fmt_sel(raw_fmt_sel), .target_addr(target_addr), .io_ref_3v3(io_ref_3v3),
    .link_active(link_active)
  );

  ccs_sensor_model u_sensor (
    .sys_clk(sys_clk), .resetn(resetn), .sensor_ref_clk_out(sensor_ref_clk_out),
    .half_period(half_period), .n_toggles(n_toggles)
  );

  // compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // counts, verdict and end of run
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle register read, expectation noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
  endtask

  // read monitor: the answer stands in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_q) begin
      check({8'h00, reg_rdata}, exp_q.pop_front());
    end
    rd_q = reg_rd;
  end

  // power cycle with given straps, straps move right after capture
  task automatic pwr_up(input logic [2:0] m, input logic [1:0] idx);
    @(posedge sys_clk);
    power_down_input     <= 1'b0;
    mode_strap           <= m;
    address_select_strap <= idx;
    repeat (2) @(posedge sys_clk);
    power_down_input     <= 1'b1;
    @(posedge sys_clk);
    mode_strap           <= ~m;
    address_select_strap <= ~idx;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // bounded wait for sensor clock edges
  task automatic wait_tog(input int n);
    int t0;
    int k;
    t0 = n_toggles;
    for (k = 0; k < 500 && n_toggles < t0 + n; k++) begin
      @(posedge sys_clk);
    end
    if (n_toggles < t0 + n) begin
      n_fail++;
      $display("wrong value at %0t ns: sensor clock stalled", $time);
      results();
    end
    @(negedge sys_clk);
  endtask

  // program ratio and measure the resulting half period
  task automatic ratio(input logic [4:0] m, input logic [2:0] d, input logic [7:0] n,
                       input logic [15:0] e);
    wr(REG_CLK_M_DIV, {d, m});
    wr(REG_CLK_N, n);
    wait_tog(5);
    check(half_period, e);
  endtask

  // main sequence
  initial begin
    logic [15:0] t;
    logic [7:0]  n;
    logic [6:0]  ta;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    check(16'(target_addr), 16'(ADDR_LO));
    check(16'(link_active), 16'h0000);
    foreach (modes[i]) begin
      for (int j = 0; j < 4; j++) begin
        pwr_up(modes[i], 2'(j));
        ta = j[0] ? ADDR_HI : ADDR_LO;
        check(16'(ref_src_sel), 16'((modes[i] == MODE_SYNC) ? REF_BC :
              (modes[i] == MODE_AON) ? REF_AON : REF_EXT));
        check(16'(parallel_video_compat_mode), 16'(modes[i] == MODE_PAR));
        check(16'(target_addr), 16'(ta));
        check(16'(io_ref_3v3), 16'(j[1]));
        check(16'(link_active), 16'h0001);
        rd(REG_MODE_SEL, {5'h00, modes[i]});
        rd(REG_TARGET, {j[1], ta});
        if (modes[i] == MODE_AON) begin
          t = n_toggles;
          repeat (300) @(posedge sys_clk);
          @(negedge sys_clk);
          check(n_toggles, t);
          check(16'(sensor_ref_clk_out), 16'h0000);
        end else begin
          wait_tog(2);
        end
      end
    end
    // override, format and read-only places
    pwr_up(MODE_SYNC, 2'h0);
    wr(REG_MODE_SEL, 8'h03);
    rd(REG_MODE_SEL, 8'h00);
    wr(REG_MODE_SEL, 8'h13);
    rd(REG_MODE_SEL, 8'h13);
    @(negedge sys_clk);
    check(16'(ref_src_sel), 16'(REF_AON));
    wr(REG_MODE_SEL, 8'h15);
    wr(REG_FMT_SEL, {6'h00, FMT_RAW_TWELVE_BIT_HIGH_FREQ});
    wr(REG_FMT_SEL, {6'h00, FMT_RAW_TWELVE_BIT_LOW_FREQ});
    rd(REG_FMT_SEL, {6'h00, FMT_RAW_TWELVE_BIT_HIGH_FREQ});
    @(negedge sys_clk);
    check(16'(parallel_video_compat_mode), 16'h0001);
    check(16'(raw_fmt_sel), 16'(FMT_RAW_TWELVE_BIT_HIGH_FREQ));
    wr(REG_TARGET, 8'hFF);
    wr(8'h20, 8'h7F);
    rd(REG_TARGET, {1'b0, ADDR_LO});
    wr(REG_MODE_SEL, 8'h02);
    wr(REG_MODE_SEL, 8'h05);
    rd(REG_MODE_SEL, 8'h02);
    rd(REG_STATUS, 8'h0B);
    // ratio table and random dividers
    foreach (tm[i]) begin
      ratio(tm[i], td[i], tn[i], te[i]);
    end
    repeat (3) begin
      n = 8'(1 + ($unsigned($random(seed)) % 8));
      ratio(5'h01, 3'h0, n, 16'(n));
    end
    // zero multiplier parks the clock, unlisted mode drops the reference
    wr(REG_CLK_M_DIV, 8'h00);
    repeat (3) @(negedge sys_clk);
    t = n_toggles;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    check(n_toggles, t);
    check(16'(sensor_ref_clk_out), 16'h0000);
    wr(REG_MODE_SEL, 8'h17);
    repeat (2) @(negedge sys_clk);
    check(16'(ref_src_sel), 16'(REF_NONE));
    check(16'(link_active), 16'h0000);
    wr(REG_MODE_SEL, 8'h02);
    // power down: link stops, writes refused, defaults restored
    @(posedge sys_clk);
    power_down_input <= 1'b0;
    repeat (4) @(negedge sys_clk);
    check(16'(link_active), 16'h0000);
    check(16'(sensor_ref_clk_out), 16'h0000);
    wr(REG_CLK_N, 8'h55);
    rd(REG_MODE_SEL, 8'h02);
    pwr_up(MODE_EXT, 2'h3);
    rd(REG_CLK_N, RST_N);
    rd(REG_CLK_M_DIV, {RST_DIV_CODE, RST_M});
    repeat (2) @(posedge sys_clk);
    results();
  end
endmodule // clkout_mode_strap_config_tb_top
